// ---- inc/compare_pkg.sv ----
// Constants and types shared by the output compare channel
`default_nettype none

package compare_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTL2_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] CMP_OFS  = 8'h08;
    localparam logic [7:0] PER_OFS  = 8'h0c;
    localparam logic [7:0] CNT_OFS  = 8'h10;

    // ------------------------------------------------------------
    // Field positions of compare_control_two
    // ------------------------------------------------------------
    localparam int FLT_EXIT_BIT = 15;
    localparam int FLT_LEVEL_BIT = 14;
    localparam int FLT_TRI_BIT = 13;
    localparam int INVERT_BIT = 12;
    localparam int CASCADE_BIT = 8;
    localparam int TRIG_MODE_BIT = 7;
    localparam int TRIG_STAT_BIT = 6;
    localparam int PIN_TRI_BIT = 5;
    localparam int SRC_MSB = 4;
    localparam int SRC_LSB = 0;

    // ------------------------------------------------------------
    // Field positions of the channel control register
    // ------------------------------------------------------------
    localparam int EN_BIT = 0;
    localparam int FLAG_BIT = 1;
    localparam int FAULT_STAT_BIT = 2;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [15:0] CTL2_RESET  = 16'h000c;
    localparam logic [15:0] CTL2_WMASK  = 16'hf1ff;
    localparam logic [31:0] CMP_RESET   = 32'h00000000;
    localparam logic [31:0] PER_RESET   = 32'h0000ffff;
    localparam logic [31:0] NARROW_MASK = 32'h0000ffff;

    // ------------------------------------------------------------
    // Fault mode states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b01,
        MODE_FAULT = 2'b10
    } fault_mode_e;

endpackage

`default_nettype wire

// ---- src/compare_channel_ctrl.sv ----
// Output compare channel with second control register on AHB-Lite
//
// Function
// - Exit select one: leave fault only when gone, flag cleared, new period.
// - Exit select zero: leave fault when gone and a new period starts.
// - During fault, output drives the fault output level.
// - During fault, tristate enable floats the pin; otherwise level applies.
// - Invert bit inverts the compare output outside fault mode.
// - Bits eleven to nine read as zero.
// - Cascade widens the time base and compare of this channel to 32 bits.
// - Trigger mode one triggers from selected source; zero synchronises to it.
// - Trigger status set by hardware on trigger; timer held clear while zero in trigger mode one.
// - Pin tristate bit floats the output; zero drives the pin except during a fault with fault tristate set.
// - Channel emits trigger-out pulse when turned off.
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none

module compare_channel_ctrl
    import compare_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic [31:0] srcPulses,
    input  wire logic        faultIn,
    output logic             cmpOut,
    output logic             cmpOe,
    output logic             trigOut
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]  ctl2;
        logic         enable;
        logic         faultFlag;
        logic [31:0]  cmpVal;
        logic [31:0]  period;
        fault_mode_e  mode;
        logic [1:0]   faultSync;
        logic         wrPend;
        logic [7:0]   wrAddr;
        logic         cmpOut;
        logic         cmpOe;
        logic         trigOut;
        logic [31:0]  hrdata;
        logic         hreadyout;
        logic         hresp;
    } chan_s;

    localparam chan_s RESET_STATE = '{
        ctl2:      CTL2_RESET,
        enable:    1'b0,
        faultFlag: 1'b0,
        cmpVal:    CMP_RESET,
        period:    PER_RESET,
        mode:      MODE_RUN,
        faultSync: 2'b00,
        wrPend:    1'b0,
        wrAddr:    8'h00,
        cmpOut:    1'b0,
        cmpOe:     1'b1,
        trigOut:   1'b0,
        hrdata:    32'h00000000,
        hreadyout: 1'b1,
        hresp:     1'b0
    };

    chan_s       q;
    chan_s       d;
    logic [31:0] count;
    logic        periodStart;
    logic        addrPhase;
    logic        srcPulse;
    logic        trigMode;
    logic        trigger_status;
    logic        faultNow;
    logic        inFault;
    logic        run;
    logic        restart;
    logic        wide;
    logic [31:0] cmpLimit;
    logic        pwmRaw;
    logic [31:0] rdVal;

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    assign addrPhase = hsel && htrans[1] && hready;
    // Same-clock sources; a channel must not pick itself
    assign srcPulse  = srcPulses[q.ctl2[SRC_MSB:SRC_LSB]];
    assign trigMode  = q.ctl2[TRIG_MODE_BIT];
    assign trigger_status  = q.ctl2[TRIG_STAT_BIT];
    assign faultNow  = q.faultSync[1];
    assign inFault   = (q.mode == MODE_FAULT);
    assign wide      = q.ctl2[CASCADE_BIT];
    assign run       = q.enable && (!trigMode || trigger_status);
    assign restart   = q.enable && !trigMode && srcPulse;
    assign cmpLimit  = wide ? q.cmpVal : (q.cmpVal & NARROW_MASK);
    assign pwmRaw    = q.enable && (count < cmpLimit);

    compare_timebase timebase (
        .clock       (clock),
        .rst_n       (rst_n),
        .clkEn       (clkEn),
        .run         (run),
        .restart     (restart),
        .wide        (wide),
        .period      (q.period),
        .count       (count),
        .periodStart (periodStart)
    );

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always_comb begin
        rdVal = 32'h00000000;
        case (haddr[7:0])
            CTL2_OFS: rdVal = {16'h0000, q.ctl2 & CTL2_WMASK};
            CTRL_OFS: rdVal = {29'h00000000, inFault, q.faultFlag, q.enable};
            CMP_OFS:  rdVal = q.cmpVal;
            PER_OFS:  rdVal = q.period;
            CNT_OFS:  rdVal = count;
            default:  rdVal = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.faultSync = {q.faultSync[0], faultIn};
        d.hreadyout = 1'b1;
        d.hresp = 1'b0;

        // Bus address and data phases
        d.wrPend = addrPhase && hwrite;
        if (addrPhase) begin
            d.wrAddr = haddr[7:0];
        end
        if (addrPhase && !hwrite) begin
            d.hrdata = rdVal;
        end
        if (q.wrPend) begin
            case (q.wrAddr)
                CTL2_OFS: d.ctl2 = hwdata[15:0] & CTL2_WMASK;
                CTRL_OFS: begin
                    d.enable = hwdata[EN_BIT];
                    if (hwdata[FLAG_BIT]) begin
                        d.faultFlag = 1'b0;
                    end
                end
                CMP_OFS:  d.cmpVal = hwdata;
                PER_OFS:  d.period = hwdata;
                default:  d.wrAddr = q.wrAddr;
            endcase
        end

        // Hardware sets win over software clears
        if (q.enable && trigMode && srcPulse) begin
            d.ctl2[TRIG_STAT_BIT] = 1'b1;
        end
        if (faultNow) begin
            d.faultFlag = 1'b1;
        end

        // Fault mode sequencing
        case (q.mode)
            MODE_RUN: begin
                if (faultNow) begin
                    d.mode = MODE_FAULT;
                end
            end
            MODE_FAULT: begin
                // Exit needs a running time base to see a new period
                if (!faultNow && periodStart && (!q.ctl2[FLT_EXIT_BIT] || !q.faultFlag)) begin
                    d.mode = MODE_RUN;
                end
            end
            default: d.mode = MODE_RUN;
        endcase

        // Pin drive
        if (inFault) begin
            d.cmpOut = q.ctl2[FLT_LEVEL_BIT];
        end else begin
            d.cmpOut = pwmRaw ^ q.ctl2[INVERT_BIT];
        end
        d.cmpOe = !(q.ctl2[PIN_TRI_BIT] || (inFault && q.ctl2[FLT_TRI_BIT]));

        // Pulse on switch-off; sources must deselect first
        d.trigOut = q.enable && !d.enable;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_STATE;
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign hreadyout = q.hreadyout;
    assign hrdata    = q.hrdata;
    assign hresp     = q.hresp;
    assign cmpOut    = q.cmpOut;
    assign cmpOe     = q.cmpOe;
    assign trigOut   = q.trigOut;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_unimpl_read_zero: assert property (
        (clkEn && addrPhase && !hwrite && haddr[7:0] == CTL2_OFS) |=> (hrdata[11:9] == 3'b000)
    ) else $error("unimplemented bits read nonzero");

    a_fault_exit_hold: assert property (
        (clkEn && inFault && q.ctl2[FLT_EXIT_BIT] && q.faultFlag) |=> inFault
    ) else $error("fault left before flag cleared");

    a_fault_auto_exit: assert property (
        (clkEn && inFault && !q.ctl2[FLT_EXIT_BIT] && !faultNow && periodStart) |=> !inFault
    ) else $error("fault not left at new period");

    a_fault_out_level: assert property (
        (clkEn && inFault) |=> (cmpOut == $past(q.ctl2[FLT_LEVEL_BIT]))
    ) else $error("fault level not driven");

    a_fault_pin_float: assert property (
        (clkEn && inFault && q.ctl2[FLT_TRI_BIT]) |=> !cmpOe
    ) else $error("pin driven during tristated fault");

    a_output_invert: assert property (
        (clkEn && !inFault) |=> (cmpOut == ($past(pwmRaw) ^ $past(q.ctl2[INVERT_BIT])))
    ) else $error("compare output polarity wrong");

    a_narrow_count: assert property (
        (clkEn && !wide && $past(clkEn) && !$past(wide)) |-> (count[31:16] == 16'h0000)
    ) else $error("count exceeds 16 bits without cascade");

    a_sync_restart: assert property (
        (clkEn && restart) |=> (count == 32'h00000000 && periodStart)
    ) else $error("sync source did not restart time base");

    a_trig_hold_clear: assert property (
        (clkEn && trigMode && !trigger_status) |=> (count == 32'h00000000)
    ) else $error("time base ran before trigger");

    a_trig_status_set: assert property (
        (clkEn && q.enable && trigMode && srcPulse) |=> trigger_status
    ) else $error("trigger status not set");

    a_pin_tristate: assert property (
        (clkEn && q.ctl2[PIN_TRI_BIT]) |=> !cmpOe
    ) else $error("pin driven while tristated");

    a_off_trig_out: assert property (
        $fell(q.enable) |-> trigOut
    ) else $error("no trigger out on switch-off");

    a_trig_out_pulse: assert property (
        (clkEn && trigOut) |=> !trigOut
    ) else $error("trigger out longer than one cycle");

    a_fault_entry: assert property (
        (clkEn && faultNow && !inFault) |=> inFault
    ) else $error("fault mode not entered");

    a_fault_pin_drive: assert property (
        (clkEn && inFault && !q.ctl2[FLT_TRI_BIT] && !q.ctl2[PIN_TRI_BIT]) |=> cmpOe
    ) else $error("pin not driven at fault level");

    a_pin_driven: assert property (
        (clkEn && !inFault && !q.ctl2[PIN_TRI_BIT]) |=> cmpOe
    ) else $error("pin floated without tristate request");

    c_fault_entry:   cover property (clkEn && !inFault ##1 inFault);
    c_fault_exit:    cover property (inFault ##1 !inFault);
    c_trig_start:    cover property (trigMode && !trigger_status ##1 trigger_status);
    c_switch_off:    cover property (trigOut);
    c_cascade_wrap:  cover property (wide && periodStart && $past(count[31:16]) != 16'h0000);

endmodule // compare_channel_ctrl

`default_nettype wire

// ---- src/compare_timebase.sv ----
// Time base of the compare channel: 16 or 32 bit period counter
`default_nettype none

module compare_timebase
    import compare_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        run,
    input  wire logic        restart,
    input  wire logic        wide,
    input  wire logic [31:0] period,
    output logic      [31:0] count,
    output logic             periodStart
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] count;
        logic        periodStart;
    } tb_s;

    tb_s         q;
    tb_s         d;
    logic [31:0] limit;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.periodStart = 1'b0;
        // Narrow mode never counts past 16 bits
        limit = wide ? period : (period & NARROW_MASK);
        if (!run) begin
            d.count = '0;
        end else if (restart || q.count >= limit) begin
            d.count = '0;
            d.periodStart = 1'b1;
        end else begin
            d.count = q.count + 32'h00000001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign count       = q.count;
    assign periodStart = q.periodStart;

endmodule // compare_timebase

`default_nettype wire

// ---- tb/src_model.sv ----
// Model of the trigger and sync sources and of the fault input
`default_nettype none

module src_model (
    input  wire logic        clock,
    input  wire logic        fire,
    input  wire logic [4:0]  idx,
    input  wire logic        faultOn,
    output logic      [31:0] srcPulses,
    output logic             faultIn
);
    timeunit 1ns;
    timeprecision 1ns;

    initial srcPulses = 32'h0;
    initial faultIn = 1'b0;

    // One-cycle pulse on the chosen line only; idle sources stay low
    always @(posedge clock) begin
        srcPulses <= fire ? (32'h1 << idx) : 32'h0;
        faultIn   <= faultOn;
    end
endmodule // src_model

`default_nettype wire

// ---- tb/tb_output_compare_ctrl2.sv ----
// Self-checking bench for the output compare channel
`default_nettype none
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb_output_compare_ctrl2
    import compare_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock, rst_n, clkEn, hsel, hwrite, fire, faultOn;
    logic        hreadyout, hresp, cmpOut, cmpOe, trigOut, faultIn;
    logic [31:0] haddr, hwdata, hrdata, srcPulses, rd;
    logic [1:0]  htrans;
    logic [4:0]  idx;
    int          miscompares = 0, cmpCount = 0, cycles = 0, trigCount = 0, t;
    int          seed = 20647, ctl2 = CTL2_RESET;

    compare_channel_ctrl dut_u (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .srcPulses(srcPulses),
        .faultIn(faultIn), .cmpOut(cmpOut), .cmpOe(cmpOe), .trigOut(trigOut));

    src_model src_u (.clock(clock), .fire(fire), .idx(idx), .faultOn(faultOn),
        .srcPulses(srcPulses), .faultIn(faultIn));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Hang guard: the whole run needs well under this
    always @(posedge clock) begin
        cycles++;
        if (trigOut === 1'b1) trigCount++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic busOp(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a == CTL2_OFS) ctl2 = d & CTL2_WMASK;
        busOp(1'b1, a, d);
    endtask

    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
        busOp(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic pins(input int n, input logic o, input logic e);
        repeat (n) @(posedge clock);
        `CHK("cmpOut", o, cmpOut)
        `CHK("cmpOe", e, cmpOe)
    endtask

    task automatic pulse(input logic [4:0] i);
        idx <= i;
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        fire = 1'b0;
        idx = 5'h0;
        faultOn = 1'b0;
        clkEn = 1'b1;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        pins(1, 1'b0, 1'b1);
        rdChk("ctl2", CTL2_OFS, ctl2);
        rdChk("unmapped", 8'h40, 32'h0);
        // Channel off, so trigger status keeps what was written
        for (int i = 0; i < 4; i++) begin
            wr(CTL2_OFS, $random(seed));
            rdChk("ctl2", CTL2_OFS, ctl2);
        end
        wr(CTL2_OFS, 32'h20);
        pins(3, 1'b0, 1'b0);
        wr(CTL2_OFS, 32'h0);
        pins(3, 1'b0, 1'b1);
        wr(PER_OFS, 32'h7);
        wr(CTRL_OFS, 32'h1);
        wr(CTL2_OFS, 32'h1000);
        pins(3, 1'b1, 1'b1);
        wr(CTL2_OFS, 32'h0);
        pins(3, 1'b0, 1'b1);
        wr(CMP_OFS, 32'h10000);
        pins(3, 1'b0, 1'b1);
        wr(CTL2_OFS, 32'h100);
        pins(3, 1'b1, 1'b1);
        wr(CMP_OFS, 32'h0);
        wr(CTL2_OFS, 32'hc000);
        clkEn <= 1'b0;
        faultOn <= 1'b1;
        pins(8, 1'b0, 1'b1);
        clkEn <= 1'b1;
        pins(8, 1'b1, 1'b1);
        wr(CTL2_OFS, 32'he000);
        repeat (3) @(posedge clock);
        `CHK("cmpOe", 1'b0, cmpOe)
        wr(CTL2_OFS, 32'h8000);
        pins(3, 1'b0, 1'b1);
        faultOn <= 1'b0;
        repeat (20) @(posedge clock);
        rdChk("ctrl", CTRL_OFS, 32'h7);
        wr(CTRL_OFS, 32'h3);
        repeat (20) @(posedge clock);
        rdChk("ctrl", CTRL_OFS, 32'h1);
        wr(CTL2_OFS, 32'h0);
        faultOn <= 1'b1;
        repeat (8) @(posedge clock);
        faultOn <= 1'b0;
        repeat (20) @(posedge clock);
        rdChk("ctrl", CTRL_OFS, 32'h3);
        t = trigCount;
        wr(CTRL_OFS, 32'h2);
        repeat (3) @(posedge clock);
        `CHK("trigs", t + 1, trigCount)
        wr(CTL2_OFS, 32'h83);
        wr(CTRL_OFS, 32'h1);
        rdChk("ctl2", CTL2_OFS, 32'h83);
        rdChk("count", CNT_OFS, 32'h0);
        pulse(5'd3);
        rdChk("ctl2", CTL2_OFS, 32'hc3);
        wr(CTL2_OFS, 32'h04);
        pulse(5'd4);
        rdChk("ctl2", CTL2_OFS, 32'h04);
        wr(CTRL_OFS, 32'h0);
        conclude();
    end
endmodule // tb_output_compare_ctrl2

`default_nettype wire
